/* core/dma_context_rx.sv */
// Descriptor context control with receive FIFO request credit gating
// Operation
// RQ1 - Bad block count at start or fetch sets dead, unknown event, no processing
// RQ2 - Software checks run, active, dead are zero, loads pointer, then sets run
// RQ3 - Software appends by formatting list, then patching last branch and count
// RQ4 - Software sets wake after linking; an idle context resumes fetching
// RQ5 - Run cleared; active cleared only once context processing has stopped
// RQ6 - Context state evaluated once per scheduling pulse
// RQ7 - Physical requests pass without credit and never stall other classes
// RQ8 - Self-ID format packets are self-ID only in the self-ID phase
// RQ9 - Self-ID acceptance programmable; accepted ones bypass the shared FIFO
// RQ10 - Responses with no memory space may be dropped
// RQ11 - Requests get busy acknowledge while the FIFO is full
// RQ12 - No request enters the FIFO without reserved memory space
// RQ13 - Credit counter held at zero while run is clear
// RQ14 - Fetched descriptor request length is added to the credit counter
// RQ15 - Requests accepted only with credit; each non-physical quadlet decrements
// RQ16 - Last credit holds the footer, else error value and busy acknowledge
// RQ17 - Extra space values written by software add to the credit
// RQ18 - Next descriptor is prefetched beyond the current one
// RQ19 - Backout counter returns reclaimed credit for errored request packets
// RQ20 - Quadlet length is 14 bits, credit counter 15 bits
// RQ21 - Branch with zero block count ends the list and clears active
// RQ22 - Dead clears active, keeps run, flags unrecoverable error, no completion
// RQ23 - Wake is cleared before each descriptor fetch
// RQ24 - Reset clears credit and backout counters
//
// Local design decisions: the address map and the strobed register port.
`default_nettype none
module dma_context_rx
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_sched,
  output logic o_fetch,
  output logic [27:0] o_fetch_addr,
  input wire dma_ctx_pkg::desc_t i_desc,
  input wire dma_ctx_pkg::link_quad_t i_lq,
  input wire logic [31:0] i_footer,
  input wire logic i_fifo_full,
  input wire logic i_resp_space,
  input wire logic i_selfid_phase,
  input wire logic i_sys_pop,
  input wire logic i_sys_sop,
  input wire logic i_sys_end_err,
  output dma_ctx_pkg::fifo_ent_t o_fifo,
  output logic o_selfid_vld,
  output logic [31:0] o_selfid_data,
  output logic o_ack_busy,
  output logic o_resp_drop,
  output logic o_unrec_err,
  output logic o_ctx_event
);
  import dma_ctx_pkg::*;

  ctx_state_t st_q;
  link_state_t lk_q;
  link_state_t lk_d;
  logic run_q;
  logic wake_q;
  logic dead_q;
  logic active_q;
  logic act_prev_q;
  logic start_pend_q;
  logic selfid_en_q;
  logic phys_q;
  logic [4:0] evt_q;
  logic [27:0] ptr_q;
  logic [3:0] z_q;
  logic [14:0] credit_q;
  logic [14:0] back_cnt_q;
  logic [14:0] back_add_q;
  logic [14:0] len_add;
  logic [14:0] space_add;
  logic [16:0] credit_sum;
  logic [31:0] ctrl_rd;
  logic link_dec;
  logic busy_d;
  logic rdrop_d;
  logic sv_d;
  fifo_ent_t fifo_d;
  logic ctrl_wr;
  logic ptr_wr;
  logic space_wr;
  logic go;
  logic desc_take;

  function automatic logic z_valid(input logic [3:0] z);
    return (z >= Z_MIN) && (z <= Z_MAX);
  endfunction

  assign ctrl_wr = i_wr && (i_addr == REG_CTRL);
  assign ptr_wr = i_wr && (i_addr == REG_PTR);
  assign space_wr = i_wr && (i_addr == REG_SPACE);
  assign go = i_sched && run_q && (start_pend_q || wake_q);
  assign desc_take = (st_q == ST_FETCH) && i_desc.valid;

  ////////////////////////////////////////////////////////////////////////////
  // Context control state machine
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= ST_IDLE;
      run_q <= 1'b0;
      wake_q <= 1'b0;
      dead_q <= 1'b0;
      active_q <= 1'b0;
      start_pend_q <= 1'b0;
      selfid_en_q <= 1'b0;
      evt_q <= 5'h00;
      ptr_q <= 28'h000_0000;
      z_q <= 4'h0;
      o_fetch <= 1'b0;
      o_fetch_addr <= 28'h000_0000;
      o_unrec_err <= 1'b0;
    end
    else
    begin
      o_unrec_err <= 1'b0;
      if (ptr_wr)
      begin
        ptr_q <= i_wdata[31:PTR_LSB];
        z_q <= i_wdata[3:0];
      end
      if (ctrl_wr)
      begin
        run_q <= i_wdata[RUN_BIT];
        selfid_en_q <= i_wdata[SELFID_BIT];
      end
      if (ctrl_wr && !i_wdata[RUN_BIT])
      begin
        dead_q <= 1'b0;
        start_pend_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE:
        begin
          if (ctrl_wr && i_wdata[RUN_BIT] && !run_q)
          begin
            if (!z_valid(z_q)) // RQ1
            begin
              dead_q <= 1'b1;
              evt_q <= EVT_UNKNOWN;
              o_unrec_err <= 1'b1; // RQ22
              st_q <= ST_DEAD;
            end
            else
            begin
              start_pend_q <= 1'b1;
            end
          end
          else if (go) // RQ4 RQ6
          begin
            wake_q <= 1'b0; // RQ23
            start_pend_q <= 1'b0;
            active_q <= 1'b1;
            o_fetch <= 1'b1;
            o_fetch_addr <= ptr_q;
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (i_desc.valid)
          begin
            o_fetch <= 1'b0;
            if (!z_valid(i_desc.z)) // RQ1
            begin
              dead_q <= 1'b1;
              evt_q <= EVT_UNKNOWN;
              active_q <= 1'b0; // RQ22
              o_unrec_err <= 1'b1;
              st_q <= ST_DEAD;
            end
            else if (i_desc.branch_z == 4'h0) // RQ21
            begin
              active_q <= 1'b0;
              st_q <= ST_IDLE;
            end
            else
            begin
              ptr_q <= i_desc.branch_addr;
              z_q <= i_desc.branch_z;
              st_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          if (i_sched) // RQ6
          begin
            if (!run_q) // RQ5
            begin
              active_q <= 1'b0;
              st_q <= ST_IDLE;
            end
            else
            begin
              wake_q <= 1'b0; // RQ23
              o_fetch <= 1'b1; // RQ18
              o_fetch_addr <= ptr_q;
              st_q <= ST_FETCH;
            end
          end
        end
        ST_DEAD:
        begin
          active_q <= 1'b0; // RQ22
          if (!run_q)
          begin
            st_q <= ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
      if (ctrl_wr && i_wdata[WAKE_BIT] && (run_q || i_wdata[RUN_BIT])) // RQ4
      begin
        wake_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion event, withheld while dead
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      act_prev_q <= 1'b0;
      o_ctx_event <= 1'b0;
    end
    else
    begin
      act_prev_q <= active_q;
      o_ctx_event <= act_prev_q && !active_q && !run_q && !dead_q; // RQ22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side credit counter
  always_comb
  begin
    len_add = desc_take && z_valid(i_desc.z) ? {1'b0, i_desc.req_len} : 15'h0000; // RQ14
    space_add = space_wr ? i_wdata[CREDIT_W-1:0] : 15'h0000; // RQ17
    credit_sum = {2'b00, credit_q} + {2'b00, len_add} + {2'b00, space_add}
      + {2'b00, back_add_q} - {16'h0000, link_dec};
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      credit_q <= 15'h0000; // RQ24
    end
    else if (!run_q)
    begin
      credit_q <= 15'h0000; // RQ13
    end
    else if (credit_sum > CREDIT_SAT) // RQ20
    begin
      credit_q <= CREDIT_MAX;
    end
    else
    begin
      credit_q <= credit_sum[CREDIT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Incoming packet sorting
  always_comb
  begin
    lk_d = lk_q;
    fifo_d = '0;
    sv_d = 1'b0;
    busy_d = 1'b0;
    rdrop_d = 1'b0;
    link_dec = 1'b0;
    case (lk_q)
      LK_IDLE:
      begin
        if (i_lq.valid && i_lq.sop)
        begin
          if (i_lq.selfid_fmt && (i_lq.cls == CLS_PHY) && i_selfid_phase) // RQ8
          begin
            sv_d = selfid_en_q; // RQ9
            lk_d = i_lq.eop ? LK_IDLE : (selfid_en_q ? LK_SELF : LK_DROP);
          end
          else if ((i_lq.cls == CLS_REQ) || (i_lq.cls == CLS_PHY))
          begin
            if (i_fifo_full || (credit_q <= 15'h0001)) // RQ11 RQ12
            begin
              busy_d = 1'b1;
              lk_d = i_lq.eop ? LK_IDLE : LK_DROP;
            end
            else
            begin
              fifo_d.valid = 1'b1;
              fifo_d.data = i_lq.data;
              link_dec = 1'b1; // RQ15
              lk_d = i_lq.eop ? LK_FOOT : LK_REQ;
            end
          end
          else if ((i_lq.cls == CLS_RESP) && !i_resp_space) // RQ10
          begin
            rdrop_d = 1'b1;
            lk_d = i_lq.eop ? LK_IDLE : LK_DROP;
          end
          else
          begin
            fifo_d.valid = 1'b1; // RQ7
            fifo_d.phys = (i_lq.cls != CLS_RESP);
            fifo_d.data = i_lq.data;
            lk_d = i_lq.eop ? LK_IDLE : LK_PASS;
          end
        end
      end
      LK_REQ:
      begin
        if (i_lq.valid)
        begin
          if (credit_q > 15'h0001)
          begin
            fifo_d.valid = 1'b1;
            fifo_d.data = i_lq.data;
            link_dec = 1'b1; // RQ15
            lk_d = i_lq.eop ? LK_FOOT : LK_REQ;
          end
          else
          begin
            fifo_d.valid = (credit_q != 15'h0000); // RQ12
            fifo_d.data = ERR_QUAD; // RQ16
            fifo_d.err = 1'b1;
            link_dec = (credit_q != 15'h0000);
            busy_d = 1'b1;
            lk_d = i_lq.eop ? LK_IDLE : LK_DROP;
          end
        end
      end
      LK_FOOT:
      begin
        fifo_d.valid = 1'b1; // RQ16
        fifo_d.footer = 1'b1;
        fifo_d.data = i_footer;
        link_dec = 1'b1;
        lk_d = LK_IDLE;
      end
      LK_SELF:
      begin
        if (i_lq.valid)
        begin
          sv_d = 1'b1; // RQ9
          lk_d = i_lq.eop ? LK_IDLE : LK_SELF;
        end
      end
      LK_PASS:
      begin
        if (i_lq.valid)
        begin
          fifo_d.valid = 1'b1; // RQ7
          fifo_d.phys = phys_q;
          fifo_d.data = i_lq.data;
          lk_d = i_lq.eop ? LK_IDLE : LK_PASS;
        end
      end
      LK_DROP:
      begin
        if (i_lq.valid && i_lq.eop)
        begin
          lk_d = LK_IDLE;
        end
      end
      default:
      begin
        lk_d = LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lk_q <= LK_IDLE;
      phys_q <= 1'b0;
      o_fifo <= '0;
      o_selfid_vld <= 1'b0;
      o_selfid_data <= 32'h0000_0000;
      o_ack_busy <= 1'b0;
      o_resp_drop <= 1'b0;
    end
    else
    begin
      lk_q <= lk_d;
      if (lk_q == LK_IDLE)
      begin
        phys_q <= (i_lq.cls != CLS_RESP);
      end
      o_fifo <= fifo_d;
      o_selfid_vld <= sv_d;
      o_selfid_data <= i_lq.data;
      o_ack_busy <= busy_d;
      o_resp_drop <= rdrop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System side backout counter
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      back_cnt_q <= 15'h0000; // RQ24
      back_add_q <= 15'h0000;
    end
    else
    begin
      back_add_q <= i_sys_end_err ? back_cnt_q : 15'h0000; // RQ19
      if (i_sys_pop)
      begin
        back_cnt_q <= i_sys_sop ? 15'h0001 : back_cnt_q + 15'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_comb
  begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[RUN_BIT] = run_q;
    ctrl_rd[WAKE_BIT] = wake_q;
    ctrl_rd[DEAD_BIT] = dead_q;
    ctrl_rd[ACTIVE_BIT] = active_q;
    ctrl_rd[SELFID_BIT] = selfid_en_q;
    ctrl_rd[EVT_LSB +: EVT_W] = evt_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rdata <= 32'h0000_0000;
      if (i_rd)
      begin
        case (i_addr)
          REG_CTRL: o_rdata <= ctrl_rd;
          REG_PTR: o_rdata <= {ptr_q, z_q};
          REG_CREDIT: o_rdata <= {17'h0_0000, credit_q};
          REG_BACKOUT: o_rdata <= {17'h0_0000, back_cnt_q};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_bad_start;
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_IDLE && ctrl_wr && i_wdata[RUN_BIT] && !run_q && !z_valid(z_q))
      |=> dead_q && evt_q == EVT_UNKNOWN && st_q == ST_DEAD;
  endproperty
  a_bad_start: assert property (p_bad_start) else $error("bad count not dead"); // RQ1

  property p_dead_idle;
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_DEAD) |=> !active_q && !o_fetch;
  endproperty
  a_dead_idle: assert property (p_dead_idle) else $error("dead context active"); // RQ22

  property p_stop;
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_WAIT && i_sched && !run_q) |=> !active_q ##1 !active_q;
  endproperty
  a_stop: assert property (p_stop) else $error("active kept after stop"); // RQ5

  property p_end_list;
    @(posedge i_clk) disable iff (!i_arst_n)
    (desc_take && z_valid(i_desc.z) && i_desc.branch_z == 4'h0) |=> !active_q;
  endproperty
  a_end_list: assert property (p_end_list) else $error("end of list kept active"); // RQ21

  property p_wake_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_IDLE && go && !ctrl_wr) |=> !wake_q && o_fetch;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake not cleared at fetch"); // RQ23

  property p_credit_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    !run_q |=> credit_q == 15'h0000;
  endproperty
  a_credit_hold: assert property (p_credit_hold) else $error("credit not held"); // RQ13

  property p_len_add;
    @(posedge i_clk) disable iff (!i_arst_n)
    (run_q && desc_take && z_valid(i_desc.z) && !link_dec && !space_wr
      && back_add_q == 15'h0000 && credit_q < 15'h4000)
      |=> credit_q == $past(credit_q) + {1'b0, $past(i_desc.req_len)};
  endproperty
  a_len_add: assert property (p_len_add) else $error("length not credited"); // RQ14

  property p_req_credit;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_fifo.valid && !o_fifo.phys && $past(link_dec)) |-> $past(credit_q) != 15'h0000;
  endproperty
  a_req_credit: assert property (p_req_credit) else $error("request without credit"); // RQ15

  property p_busy_full;
    @(posedge i_clk) disable iff (!i_arst_n)
    (lk_q == LK_IDLE && i_lq.valid && i_lq.sop && i_lq.cls == CLS_REQ && i_fifo_full)
      |=> o_ack_busy && !o_fifo.valid;
  endproperty
  a_busy_full: assert property (p_busy_full) else $error("full fifo not busied"); // RQ11

  property p_resp_drop;
    @(posedge i_clk) disable iff (!i_arst_n)
    (lk_q == LK_IDLE && i_lq.valid && i_lq.sop && i_lq.cls == CLS_RESP && !i_resp_space)
      |=> o_resp_drop;
  endproperty
  a_resp_drop: assert property (p_resp_drop) else $error("response not dropped"); // RQ10

  property p_backout;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_sys_end_err |=> back_add_q == $past(back_cnt_q);
  endproperty
  a_backout: assert property (p_backout) else $error("backout not returned"); // RQ19
endmodule
`default_nettype wire

/* core/dma_ctx_pkg.sv */
// Shared constants and types for the DMA context and receive credit block
`default_nettype none
package dma_ctx_pkg;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PTR = 8'h04;
  localparam logic [7:0] REG_CREDIT = 8'h08;
  localparam logic [7:0] REG_SPACE = 8'h0C;
  localparam logic [7:0] REG_BACKOUT = 8'h10;
  // Register field positions and widths
  localparam int unsigned RUN_BIT = 15;
  localparam int unsigned WAKE_BIT = 12;
  localparam int unsigned DEAD_BIT = 11;
  localparam int unsigned ACTIVE_BIT = 10;
  localparam int unsigned SELFID_BIT = 8;
  localparam int unsigned EVT_LSB = 0;
  localparam int unsigned EVT_W = 5;
  localparam int unsigned PTR_LSB = 4;
  localparam int unsigned CREDIT_W = 15;
  localparam int unsigned LEN_W = 14;
  // Event code for a bad block count (value arbitrary)
  localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
  // Valid block count range for this context
  localparam logic [3:0] Z_MIN = 4'h1;
  localparam logic [3:0] Z_MAX = 4'h1;
  // Fill value for a truncated request
  localparam logic [31:0] ERR_QUAD = 32'hFFFF_FFFF;
  localparam logic [14:0] CREDIT_MAX = 15'h7FFF;
  localparam logic [16:0] CREDIT_SAT = 17'h0_7FFF;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_WAIT = 2'b11,
    ST_DEAD = 2'b10} ctx_state_t;
  typedef enum logic [2:0] {LK_IDLE = 3'b000, LK_REQ = 3'b001, LK_FOOT = 3'b011,
    LK_DROP = 3'b010, LK_SELF = 3'b110, LK_PASS = 3'b111} link_state_t;
  typedef enum logic [2:0] {CLS_REQ = 3'h0, CLS_PHYS_WR = 3'h1, CLS_PHYS_RD = 3'h2,
    CLS_RESP = 3'h3, CLS_PHY = 3'h4} pkt_class_t;
  typedef struct packed {
    logic valid;
    logic [3:0] z;
    logic [13:0] req_len;
    logic [27:0] branch_addr;
    logic [3:0] branch_z;
  } desc_t;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    pkt_class_t cls;
    logic selfid_fmt;
    logic [31:0] data;
  } link_quad_t;
  typedef struct packed {
    logic valid;
    logic footer;
    logic err;
    logic phys;
    logic [31:0] data;
  } fifo_ent_t;
endpackage
`default_nettype wire

/* verif/desc_mem_model.sv */
// Descriptor memory model that answers fetch requests after a set delay
`default_nettype none
module desc_mem_model
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_fetch,
  input wire logic [27:0] i_fetch_addr,
  input wire logic [3:0] i_delay,
  input wire logic [3:0] i_z,
  input wire logic [13:0] i_len,
  input wire logic [3:0] i_bz,
  output dma_ctx_pkg::desc_t o_desc,
  output logic [7:0] o_count,
  output logic [27:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  import dma_ctx_pkg::*;
  logic busy_q;
  logic [3:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // Fields toggle between answers; branch target is the next block
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      o_count <= '0;
      o_addr <= '0;
      o_desc <= '0;
    end
    else
    begin
      o_desc <= ~o_desc;
      o_desc.valid <= 1'b0;
      if (busy_q && cnt_q == 4'h0)
      begin
        busy_q <= 1'b0;
        o_desc <= '{1'b1, i_z, i_len, o_addr + 28'h000_0001, i_bz};
        o_count <= o_count + 8'h01;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
      else if (i_fetch && !o_desc.valid)
      begin
        busy_q <= 1'b1;
        cnt_q <= i_delay;
        o_addr <= i_fetch_addr;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/dma_context_rx_tb_top.sv */
// Self-checking bench for the DMA context receive block
`default_nettype none
module dma_context_rx_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_ctx_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] RUN = ONE << RUN_BIT;
  localparam logic [31:0] WAKE = ONE << WAKE_BIT;
  localparam logic [31:0] DEAD = ONE << DEAD_BIT;
  localparam logic [31:0] ACT = ONE << ACTIVE_BIT;
  localparam logic [31:0] SID = ONE << SELFID_BIT;
  localparam logic [31:0] CM = RUN | WAKE | DEAD | ACT;
  localparam logic [31:0] EVM = 32'h0000_001f;
  localparam int NF = 0, NE = 1, NT = 2, NP = 3, NB = 4, ND = 5, NS = 6, NU = 7, NC = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sched = 1'b0;
  link_quad_t lq = '0;
  logic [31:0] footer = '0;
  logic ffull = 1'b0;
  logic rspace = 1'b1;
  logic sphase = 1'b0;
  logic pop = 1'b0;
  logic psop = 1'b0;
  logic perr = 1'b0;
  logic [3:0] dly = '0;
  logic [3:0] mz = 4'h1;
  logic [3:0] mbz = 4'h1;
  logic [13:0] mlen = '0;
  logic [31:0] rdata, sid_data, last_d, sid_d, tx;
  logic fetch, sid_vld, busy, rdrop, unrec, cev;
  logic [27:0] fetch_addr, maddr;
  logic [7:0] served;
  desc_t desc;
  fifo_ent_t fifo;
  logic [31:0] seed = 32'h9e44_6d7f;
  int n [9];
  int bad_count = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Design, descriptor memory and clock
  dma_context_rx dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sched(sched), .o_fetch(fetch),
    .o_fetch_addr(fetch_addr), .i_desc(desc), .i_lq(lq), .i_footer(footer),
    .i_fifo_full(ffull), .i_resp_space(rspace), .i_selfid_phase(sphase), .i_sys_pop(pop),
    .i_sys_sop(psop), .i_sys_end_err(perr), .o_fifo(fifo), .o_selfid_vld(sid_vld),
    .o_selfid_data(sid_data), .o_ack_busy(busy), .o_resp_drop(rdrop), .o_unrec_err(unrec),
    .o_ctx_event(cev));
  desc_mem_model mem (.i_clk(clk), .i_arst_n(arst_n), .i_fetch(fetch),
    .i_fetch_addr(fetch_addr), .i_delay(dly), .i_z(mz), .i_len(mlen), .i_bz(mbz),
    .o_desc(desc), .o_count(served), .o_addr(maddr));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Pulse counters
  always @(posedge clk)
  begin
    if (fifo.valid === 1'b1)
    begin
      n[NF]++;
      n[NE] += int'(fifo.err === 1'b1);
      n[NT] += int'(fifo.footer === 1'b1);
      n[NP] += int'(fifo.phys === 1'b1);
      last_d = fifo.data;
    end
    if (sid_vld === 1'b1)
      sid_d = sid_data;
    n[NS] += int'(sid_vld === 1'b1);
    n[NB] += int'(busy === 1'b1);
    n[ND] += int'(rdrop === 1'b1);
    n[NU] += int'(unrec === 1'b1);
    n[NC] += int'(cev === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int req_ents(input int cr, input int len);
    if (cr <= 1)
      return 0;
    if (len < cr)
      return len + 1;
    return cr;
  endfunction
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic sp();
    @(posedge clk);
    sched <= 1'b1;
    @(posedge clk);
    sched <= 1'b0;
  endtask
  task automatic fetch_wait();
    logic [7:0] s;
    s = served;
    sp();
    for (int i = 0; i < 64 && served === s; i++)
      @(posedge clk);
    if (served === s)
    begin
      bad_count++;
      end_sim();
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic send(input pkt_class_t c, input int len, input logic sf);
    n = '{default: 0};
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      tx = rnd();
      lq <= '{1'b1, i == 0, i == len - 1, c, sf, tx};
    end
    @(posedge clk);
    lq.valid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [27:0] a;
    logic [3:0] badz [3];
    int c;
    int k;
    badz = '{4'h0, 4'h2, 4'hf};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    ck(REG_CTRL, '1, 32'h0);
    ck(REG_CREDIT, '1, 32'h0);
    ck(REG_BACKOUT, '1, 32'h0);
    ck(8'h20, '1, 32'h0);
    foreach (badz[i])
    begin
      n = '{default: 0};
      wreg(REG_PTR, {28'h000_0100, badz[i]});
      wreg(REG_CTRL, RUN);
      ck(REG_CTRL, CM | EVM, RUN | DEAD | 32'(EVT_UNKNOWN));
      k = served;
      sp();
      repeat (20) @(posedge clk);
      chk(served, k);
      chk(n[NU], 1);
      chk(n[NC], 0);
      wreg(REG_CTRL, 32'h0);
      ck(REG_CTRL, CM, 32'h0);
    end
    a = 28'(rnd());
    mlen <= 14'(rnd() % 8 + 4);
    dly <= 4'(rnd());
    wreg(REG_PTR, {a, 4'h1});
    wreg(REG_CTRL, RUN);
    c = mlen;
    repeat (6) @(posedge clk);
    ck(REG_CTRL, CM, RUN);
    fetch_wait();
    chk(maddr, a);
    ck(REG_CTRL, CM, RUN | ACT);
    ck(REG_CREDIT, '1, c);
    mlen <= 14'(rnd() % 8 + 4);
    mbz <= 4'h0;
    dly <= 4'(rnd());
    fetch_wait();
    c += mlen;
    chk(maddr, a + 28'h000_0001);
    ck(REG_CREDIT, '1, c);
    ck(REG_CTRL, CM, RUN);
    k = rnd() % 16 + 1;
    wreg(REG_SPACE, k);
    c += k;
    ck(REG_CREDIT, '1, c);
    footer <= rnd();
    send(CLS_REQ, 2, 1'b0);
    chk(n[NF], req_ents(c, 2));
    chk(n[NT], 1);
    chk(last_d, footer);
    c -= 3;
    ck(REG_CREDIT, '1, c);
    send(CLS_PHYS_WR, 3, 1'b0);
    chk(n[NP], 3);
    send(CLS_PHYS_RD, 1, 1'b0);
    chk(n[NB], 0);
    ck(REG_CREDIT, '1, c);
    rspace <= 1'b0;
    send(CLS_RESP, 2, 1'b0);
    chk(n[ND], 1);
    rspace <= 1'b1;
    send(CLS_RESP, 2, 1'b0);
    chk(n[ND], 0);
    chk(n[NF], 2);
    chk(n[NP], 0);
    ck(REG_CREDIT, '1, c);
    wreg(REG_CTRL, RUN | SID);
    sphase <= 1'b1;
    send(CLS_PHY, 1, 1'b1);
    chk(n[NS], 1);
    chk(sid_d, tx);
    ck(REG_CREDIT, '1, c);
    sphase <= 1'b0;
    send(CLS_PHY, 1, 1'b1);
    chk(n[NS], 0);
    chk(n[NF], req_ents(c, 1));
    c -= 2;
    ck(REG_CREDIT, '1, c);
    wreg(REG_CTRL, RUN);
    sphase <= 1'b1;
    send(CLS_PHY, 1, 1'b1);
    chk(n[NS] + n[NF], 0);
    sphase <= 1'b0;
    ffull <= 1'b1;
    send(CLS_REQ, 1, 1'b0);
    chk(n[NB], 1);
    chk(n[NF], 0);
    ffull <= 1'b0;
    ck(REG_CREDIT, '1, c);
    k = rnd() % 6 + 2;
    for (int i = 0; i < k; i++)
    begin
      @(posedge clk);
      pop <= 1'b1;
      psop <= i == 0;
    end
    @(posedge clk);
    pop <= 1'b0;
    ck(REG_BACKOUT, '1, k);
    @(posedge clk);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    repeat (3) @(posedge clk);
    c += k;
    ck(REG_CREDIT, '1, c);
    send(CLS_REQ, c + 2, 1'b0);
    chk(n[NF], req_ents(c, c + 2));
    chk(n[NE], 1);
    chk(n[NB], 1);
    chk(n[NT], 0);
    chk(last_d, ERR_QUAD);
    send(CLS_REQ, 1, 1'b0);
    chk(n[NB], 1);
    chk(n[NF], 0);
    mbz <= 4'h1;
    wreg(REG_CTRL, RUN | WAKE);
    fetch_wait();
    chk(maddr, a + 28'h000_0001);
    ck(REG_CTRL, CM, RUN | ACT);
    n = '{default: 0};
    wreg(REG_CTRL, 32'h0);
    ck(REG_CTRL, CM, ACT);
    sp();
    repeat (3) @(posedge clk);
    ck(REG_CTRL, CM, 32'h0);
    chk(n[NC], 1);
    ck(REG_CREDIT, '1, 32'h0);
    mz <= 4'h2;
    wreg(REG_PTR, {a, 4'h1});
    wreg(REG_CTRL, RUN);
    fetch_wait();
    ck(REG_CTRL, CM | EVM, RUN | DEAD | 32'(EVT_UNKNOWN));
    chk(n[NU], 1);
    chk(n[NC], 1);
    end_sim();
  end
endmodule
`default_nettype wire
